// >>> sim/cmc_bus_model.sv
// Bus model: wired-AND line with another node and a bit-time tick
`timescale 1ns/100ps
`default_nettype none
module cmc_bus_model #(
	parameter int TICK = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Node side
	input wire logic can_transmit_pin,
	input wire logic other_dom,
	output logic can_receive_pin,
	output logic bit_tick
);
	logic [7:0] div_q;
	// Dominant wins; an idle bus reads recessive
	assign can_receive_pin = can_transmit_pin & ~other_dom;
	// Free running so the idle bus keeps counting recessive bits
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div_q <= 8'h00;
			bit_tick <= 1'b0;
		end
		else
		begin
			div_q <= (div_q == 8'(TICK - 1)) ? 8'h00 : div_q + 8'h01;
			bit_tick <= (div_q == 8'(TICK - 1));
		end
	end
endmodule // cmc_bus_model
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench of the CAN mode and control block
`timescale 1ns/100ps
`default_nettype none
`include "cmc_params.svh"
module testbench;
	localparam logic [7:0] AC = `CMC_ADDR_CTRL, AS = `CMC_ADDR_STAT;
	localparam logic [7:0] AT = `CMC_ADDR_TEC, AR = `CMC_ADDR_REC;
	localparam logic [31:0] TBL [7] = '{32'h81a66010, 32'h81a65f00, 32'h83a66000,
		32'h83a68010, 32'h83a78111, 32'h83a60011, 32'h83a70000};
	logic clk, rstn, sfr_wr, sfr_rd, timed_ok, cie, gie, rx_active, engine_tx, rx_ok;
	logic tx_ok, tx_err_inc, err_event, mem_wr, other_dom, bit_tick, rx_pin, tx_pin;
	logic error_irq, status_irq, engine_rx, bus_enable, error_passive, mem_wr_ok, low_power;
	logic [7:0] maq, mwq;
	logic [2:0] err_code;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, bt0, bt1, mem_addr, mem_wdata, v;
	int error_cnt, n_checks, n;

	cmc_ctrl DUT (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .timed_ok(timed_ok), .sfr_rdata(sfr_rdata),
		.can_irq_enable(cie), .global_irq_enable(gie), .error_irq(error_irq),
		.status_irq(status_irq), .rx_active(rx_active), .tx_active(1'b0),
		.arb_active(1'b0), .bit_tick(bit_tick), .engine_tx(engine_tx), .rx_ok(rx_ok),
		.rx_stored(1'b0), .tx_ok(tx_ok), .tx_err_inc(tx_err_inc), .rx_err_inc(1'b0),
		.err_event(err_event), .err_code(err_code), .engine_rx(engine_rx),
		.bus_enable(bus_enable), .error_passive(error_passive), .low_power(low_power),
		.bus_timing_0(bt0), .bus_timing_1(bt1), .mem_wr(mem_wr), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_wr_ok(mem_wr_ok), .mem_addr_q(maq), .mem_wdata_q(mwq),
		.can_receive_pin(rx_pin), .can_transmit_pin(tx_pin));
	cmc_bus_model #(.TICK(4)) bus (.clk(clk), .rstn(rstn), .can_transmit_pin(tx_pin),
		.other_dom(other_dom), .can_receive_pin(rx_pin), .bit_tick(bit_tick));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic t);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		timed_ok <= t;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
		timed_ok <= 1'b0;
	endtask
	task automatic rdv(input logic [7:0] a);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		@(negedge clk);
		v = sfr_rdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		rdv(a);
		chk(v & m, e);
	endtask
	// Software side keeps polling, as firmware would
	// Always reads once, so a stale value never passes; covers a full bus-off recovery
	task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		rdv(a);
		for (int i = 0; i < 4000 && (v & m) !== e; i++)
			rdv(a);
		chk(v & m, e);
	endtask
	task automatic mw(input logic [7:0] a, input logic e);
		@(posedge clk);
		mem_addr <= a;
		mem_wdata <= a ^ 8'h5a;
		mem_wr <= 1'b1;
		@(posedge clk);
		mem_wr <= 1'b0;
		@(negedge clk);
		chk({7'h0, mem_wr_ok}, {7'h0, e});
		chk(maq, a);
		chk(mwq, a ^ 8'h5a);
	endtask
	// Counts the bit ticks the block sees until it joins the bus
	task automatic wait_on;
		n = 0;
		for (int i = 0; i < 200 && bus_enable !== 1'b1; i++)
		begin
			@(posedge clk);
			if (bit_tick === 1'b1)
				n++;
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		complete_run;
	end
	initial
	begin
		// Engine idles recessive, or the line never shows a recessive run
		{rstn, sfr_wr, sfr_rd, timed_ok, rx_active, engine_tx, rx_ok, tx_ok} = 8'h04;
		{tx_err_inc, err_event, mem_wr, other_dom, err_code} = 7'h00;
		{sfr_addr, sfr_wdata, mem_addr, mem_wdata} = 32'h00000000;
		{cie, gie, bt0, bt1} = 18'h30101;
		error_cnt = 0;
		n_checks = 0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		rd(AC, 8'hff, 8'h09);
		rd(AT, 8'hff, 8'h00);
		wr(AC, 8'h00, 1'b0);
		rd(AC, 8'hff, 8'h09);
		wr(AC, 8'h00, 1'b1);
		rd(AC, 8'hff, 8'h01);
		wr(AC, 8'h21, 1'b0);
		rd(AS, 8'he0, 8'h20);
		wr(AC, 8'h11, 1'b0);
		rd(AC, 8'hff, 8'h01);
		rd(AS, 8'he0, 8'h00);
		for (int i = 0; i < 7; i++)
		begin
			wr(AC, TBL[i][31:24], 1'b0);
			wr(TBL[i][23:16], TBL[i][15:8], 1'b0);
			repeat (4) @(posedge clk);
			rd(AS, 8'h40, {1'b0, TBL[i][4], 6'h0});
			chk({7'h0, error_irq}, {7'h0, TBL[i][4]});
			chk({7'h0, error_passive}, {7'h0, TBL[i][0]});
		end
		@(posedge clk) {bt0, bt1} <= 16'h0000;
		wr(AC, 8'h00, 1'b0);
		rd(AC, 8'h01, 8'h01);
		@(posedge clk) {bt0, bt1} <= 16'h0101;
		mw(8'h0f, 1'b1);
		wr(AC, 8'h00, 1'b0);
		wait_on;
		chk({7'h0, bus_enable}, 8'h01);
		chk({7'h0, n >= 11 && n <= 12}, 8'h01);
		mw(8'h0f, 1'b0);
		mw(8'h10, 1'b1);
		wr(AT, 8'h33, 1'b0);
		rd(AT, 8'hff, 8'h00);
		wr(AC, 8'h40, 1'b0);
		@(posedge clk) tx_ok <= 1'b1;
		@(posedge clk) tx_ok <= 1'b0;
		repeat (3) @(posedge clk);
		chk({7'h0, status_irq}, 8'h01);
		rd(AS, 8'h08, 8'h08);
		@(posedge clk) {err_event, err_code} <= 4'hd;
		@(posedge clk) err_event <= 1'b0;
		repeat (3) @(posedge clk);
		chk({7'h0, status_irq}, 8'h01);
		rd(AS, 8'h07, 8'h05);
		rd(AS, 8'h07, 8'h07);
		@(posedge clk) rx_active <= 1'b1;
		wr(AC, 8'h01, 1'b0);
		repeat (4) @(posedge clk);
		rd(AC, 8'h01, 8'h00);
		@(posedge clk) rx_active <= 1'b0;
		poll(AC, 8'h01, 8'h01);
		wr(AT, 8'hf8, 1'b0);
		wr(AC, 8'h00, 1'b0);
		wait_on;
		@(posedge clk) tx_err_inc <= 1'b1;
		@(posedge clk) tx_err_inc <= 1'b0;
		repeat (3) @(posedge clk);
		rd(AS, 8'h80, 8'h80);
		rd(AC, 8'h01, 8'h00);
		wr(AC, 8'h01, 1'b0);
		repeat (3) @(posedge clk);
		rd(AC, 8'h01, 8'h00);
		poll(AS, 8'h80, 8'h00);
		rd(AC, 8'h01, 8'h01);
		rd(AT, 8'hff, 8'h00);
		rd(AR, 8'hff, 8'h00);
		wr(AC, 8'h04, 1'b0);
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk) {engine_tx, other_dom} <= (i == 0) ? 2'b10 : (i == 1) ? 2'b11 : 2'b00;
			repeat (5) @(posedge clk);
			chk({7'h0, engine_rx}, {7'h0, i == 0});
			chk({7'h0, tx_pin}, 8'h01);
		end
		@(posedge clk) rx_ok <= 1'b1;
		@(posedge clk) rx_ok <= 1'b0;
		repeat (3) @(posedge clk);
		rd(AS, 8'h10, 8'h10);
		// Power-down holds the bus; leaving it waits for a recessive run
		@(posedge clk) engine_tx <= 1'b1;
		wr(AC, 8'h20, 1'b0);
		repeat (3) @(posedge clk);
		chk({7'h0, low_power}, 8'h01);
		wr(AC, 8'h00, 1'b0);
		wait_on;
		chk({7'h0, bus_enable}, 8'h01);
		chk({7'h0, n >= 11 && n <= 12}, 8'h01);
		chk({7'h0, low_power}, 8'h00);
		wr(AC, 8'h10, 1'b0);
		repeat (3) @(posedge clk);
		chk({7'h0, low_power}, 8'h01);
		@(posedge clk) rx_active <= 1'b1;
		wr(AC, 8'h08, 1'b1);
		rd(AC, 8'h18, 8'h00);
		chk({7'h0, low_power}, 8'h00);
		@(posedge clk) rx_active <= 1'b0;
		repeat (3) @(posedge clk);
		rd(AC, 8'hff, 8'h09);
		rd(AS, 8'hff, 8'h00);
		complete_run;
	end
endmodule // testbench
`default_nettype wire

// >>> verilog/cmc_ctrl.sv
// CAN mode and control block top
`timescale 1ns/100ps
`default_nettype none
`include "cmc_params.svh"
module cmc_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Special function register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic timed_ok,
	output logic [7:0] sfr_rdata,
	// Interrupt enables outside the block
	input wire logic can_irq_enable,
	input wire logic global_irq_enable,
	output logic error_irq,
	output logic status_irq,
	// Protocol engine
	input wire logic rx_active,
	input wire logic tx_active,
	input wire logic arb_active,
	input wire logic bit_tick,
	input wire logic engine_tx,
	input wire logic rx_ok,
	input wire logic rx_stored,
	input wire logic tx_ok,
	input wire logic tx_err_inc,
	input wire logic rx_err_inc,
	input wire logic err_event,
	input wire logic [2:0] err_code,
	output logic engine_rx,
	output logic bus_enable,
	output logic error_passive,
	output logic low_power,
	// Bus timing and message memory write gate
	input wire logic [7:0] bus_timing_0,
	input wire logic [7:0] bus_timing_1,
	input wire logic mem_wr,
	input wire logic [7:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic mem_wr_ok,
	output logic [7:0] mem_addr_q,
	output logic [7:0] mem_wdata_q,
	// Transceiver pins
	input wire logic can_receive_pin,
	output logic can_transmit_pin
);
	logic rst_s1_q, rst_n_s, rx_s;
	logic error_irq_enable, status_irq_enable, power_down_request, siesta_q;
	logic module_reset, mrst_done_q, baud_detect_mode, error_threshold_select;
	logic software_init, swinit_req_q, bus_off_flag, error_count_exceeded;
	logic rxs_q, txs_q, wks_prev_q, stat_pend_q, lp_active_q, run_done;
	logic [2:0] bus_error_field;
	logic [8:0] tx_error_counter, rx_error_counter;
	logic [7:0] recov_cnt_q;
	cmc_pkg::cmc_bus_t bus_q;
	logic busy, soft_rst, wr_ctrl, wr_stat, rd_stat, wr_tec, wr_rec, timing_zero;
	logic wake_status, tx_rise, rx_set, er_new, run_clear, rx_fb, bus_off_hit;

	assign busy = rx_active | tx_active | arb_active;
	assign wr_ctrl = sfr_wr && (sfr_addr == `CMC_ADDR_CTRL);
	assign wr_stat = sfr_wr && (sfr_addr == `CMC_ADDR_STAT);
	assign rd_stat = sfr_rd && (sfr_addr == `CMC_ADDR_STAT);
	assign wr_tec = sfr_wr && (sfr_addr == `CMC_ADDR_TEC);
	assign wr_rec = sfr_wr && (sfr_addr == `CMC_ADDR_REC);
	assign timing_zero = (bus_timing_0 == 8'h00) && (bus_timing_1 == 8'h00);
	assign wake_status = power_down_request | siesta_q;
	assign soft_rst = module_reset && (mrst_done_q || !busy);
	assign rx_set = rx_ok && (baud_detect_mode || rx_stored);
	assign tx_rise = tx_ok && !txs_q;
	assign er_new = err_event && ((bus_error_field == `CMC_ER_NONE)
		|| (bus_error_field == `CMC_ER_NOCHG)) && (err_code != `CMC_ER_NONE)
		&& (err_code != `CMC_ER_NOCHG);
	assign bus_off_hit = (bus_q == cmc_pkg::CMC_ON) && tx_err_inc
		&& (tx_error_counter >= `CMC_BUS_OFF - `CMC_TX_ERR_STEP);
	assign rx_fb = baud_detect_mode ? (rx_s & engine_tx) : rx_s;
	assign run_clear = !((bus_q == cmc_pkg::CMC_WAIT) || (bus_q == cmc_pkg::CMC_RECOVER))
		|| lp_active_q;

	// Reset release
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_s1_q <= 1'b0;
			rst_n_s <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n_s <= rst_s1_q;
		end
	end

	cmc_sync u_rx_sync (
		.clk(clk),
		.rst_n(rst_n_s),
		.d(can_receive_pin),
		.q(rx_s)
	);

	cmc_run u_run (
		.clk(clk),
		.rst_n(rst_n_s),
		.clear(run_clear),
		.bit_tick(bit_tick),
		.bit_val(rx_fb),
		.run_done(run_done)
	);

	// Plain control bits
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			error_irq_enable <= 1'b0;
			status_irq_enable <= 1'b0;
			power_down_request <= 1'b0;
			siesta_q <= 1'b0;
			baud_detect_mode <= 1'b0;
			error_threshold_select <= 1'b0;
		end
		else if (soft_rst)
		begin
			error_irq_enable <= 1'b0;
			status_irq_enable <= 1'b0;
			power_down_request <= 1'b0;
			siesta_q <= 1'b0;
			baud_detect_mode <= 1'b0;
			error_threshold_select <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			error_irq_enable <= sfr_wdata[`CMC_B_ERRIE];
			status_irq_enable <= sfr_wdata[`CMC_B_STATUS_IRQ_ENABLE];
			power_down_request <= sfr_wdata[`CMC_B_PDE];
			siesta_q <= sfr_wdata[`CMC_B_SIESTA] && !sfr_wdata[`CMC_B_SWINIT]
				&& !(timed_ok && sfr_wdata[`CMC_B_MRST]);
			baud_detect_mode <= sfr_wdata[`CMC_B_BAUD];
			error_threshold_select <= sfr_wdata[`CMC_B_THR];
		end
	end

	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			module_reset <= 1'b1;
			mrst_done_q <= 1'b1;
		end
		else
		begin
			if (wr_ctrl && timed_ok)
				module_reset <= sfr_wdata[`CMC_B_MRST];
			if (wr_ctrl && timed_ok && !sfr_wdata[`CMC_B_MRST])
				mrst_done_q <= 1'b0;
			else if (wr_ctrl && timed_ok && !module_reset)
				mrst_done_q <= 1'b0;
			else if (soft_rst)
				mrst_done_q <= 1'b1;
		end
	end

	// Software init lockout
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			software_init <= 1'b1;
			swinit_req_q <= 1'b0;
		end
		else if (soft_rst)
		begin
			software_init <= 1'b1;
			swinit_req_q <= 1'b0;
		end
		else if (bus_off_hit || bus_q == cmc_pkg::CMC_RECOVER)
		begin
			software_init <= (bus_q == cmc_pkg::CMC_RECOVER) && run_done
				&& (recov_cnt_q == `CMC_RECOV_RUNS - 8'h01);
			swinit_req_q <= 1'b0;
		end
		else if (timing_zero)
		begin
			software_init <= 1'b1;
			swinit_req_q <= 1'b0;
		end
		else if (wr_ctrl && !bus_off_flag)
		begin
			if (!sfr_wdata[`CMC_B_SWINIT])
			begin
				software_init <= 1'b0;
				swinit_req_q <= 1'b0;
			end
			else if (!software_init)
				swinit_req_q <= 1'b1;
		end
		else if (swinit_req_q && (!busy || err_event))
		begin
			software_init <= 1'b1;
			swinit_req_q <= 1'b0;
		end
	end

	// Low power entry after current activity
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			lp_active_q <= 1'b0;
		else if (!wake_status || soft_rst)
			lp_active_q <= 1'b0;
		else if (!busy)
			lp_active_q <= 1'b1;
	end

	// Bus sequencer
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			bus_q <= cmc_pkg::CMC_OFFLINE;
			recov_cnt_q <= 8'h00;
		end
		else if (soft_rst)
		begin
			bus_q <= cmc_pkg::CMC_OFFLINE;
			recov_cnt_q <= 8'h00;
		end
		else
		begin
			case (bus_q)
				cmc_pkg::CMC_OFFLINE:
					if (!software_init)
						bus_q <= cmc_pkg::CMC_WAIT;
				cmc_pkg::CMC_WAIT:
					if (software_init)
						bus_q <= cmc_pkg::CMC_OFFLINE;
					else if (run_done)
						bus_q <= cmc_pkg::CMC_ON;
				cmc_pkg::CMC_ON:
					if (bus_off_hit)
					begin
						bus_q <= cmc_pkg::CMC_RECOVER;
						recov_cnt_q <= 8'h00;
					end
					else if (software_init)
						bus_q <= cmc_pkg::CMC_OFFLINE;
					else if (lp_active_q)
						bus_q <= cmc_pkg::CMC_WAIT;
				default:
					if (run_done)
					begin
						recov_cnt_q <= recov_cnt_q + 8'h01;
						if (recov_cnt_q == `CMC_RECOV_RUNS - 8'h01)
							bus_q <= cmc_pkg::CMC_OFFLINE;
					end
			endcase
		end
	end

	// Error counters and fault confinement
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			tx_error_counter <= 9'h000;
			rx_error_counter <= 9'h000;
			bus_off_flag <= 1'b0;
		end
		else if (soft_rst)
		begin
			tx_error_counter <= 9'h000;
			rx_error_counter <= 9'h000;
			bus_off_flag <= 1'b0;
		end
		else if (bus_off_hit)
		begin
			tx_error_counter <= `CMC_BUS_OFF;
			bus_off_flag <= 1'b1;
		end
		else if (bus_q == cmc_pkg::CMC_RECOVER)
		begin
			// recovery end clears flag and counters
			if (run_done && (recov_cnt_q == `CMC_RECOV_RUNS - 8'h01))
			begin
				tx_error_counter <= 9'h000;
				rx_error_counter <= 9'h000;
				bus_off_flag <= 1'b0;
			end
		end
		else
		begin
			if (wr_tec && software_init)
				tx_error_counter <= {1'b0, sfr_wdata};
			else if (tx_err_inc)
				tx_error_counter <= tx_error_counter + `CMC_TX_ERR_STEP;
			else if (tx_ok && tx_error_counter != 9'h000)
				tx_error_counter <= tx_error_counter - 9'h001;
			if (wr_rec && software_init)
				rx_error_counter <= {1'b0, sfr_wdata};
			else if (rx_err_inc && rx_error_counter != 9'h0ff)
				rx_error_counter <= rx_error_counter + 9'h001;
			else if (rx_ok && rx_error_counter != 9'h000)
				rx_error_counter <= rx_error_counter - 9'h001;
		end
	end

	// Status flags
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			rxs_q <= 1'b0;
			txs_q <= 1'b0;
			bus_error_field <= `CMC_ER_NONE;
			wks_prev_q <= 1'b0;
			stat_pend_q <= 1'b0;
		end
		else if (soft_rst)
		begin
			rxs_q <= 1'b0;
			txs_q <= 1'b0;
			bus_error_field <= `CMC_ER_NONE;
			wks_prev_q <= 1'b0;
			stat_pend_q <= 1'b0;
		end
		else
		begin
			wks_prev_q <= wake_status;
			// Engine set wins over a software clear
			rxs_q <= rx_set || (wr_stat ? sfr_wdata[4] : rxs_q);
			txs_q <= tx_ok || (wr_stat ? sfr_wdata[3] : txs_q);
			if (er_new)
				bus_error_field <= err_code;
			else if (rd_stat && !software_init)
				bus_error_field <= `CMC_ER_NOCHG;
			if (status_irq_enable && (rx_set || tx_ok || er_new
				|| (wake_status && !wks_prev_q)
				|| (wr_stat && sfr_wdata[4] && !rxs_q)
				|| (wr_stat && sfr_wdata[3] && !txs_q)))
				stat_pend_q <= 1'b1;
			else if (rd_stat)
				stat_pend_q <= 1'b0;
		end
	end

	// Threshold flag, interrupts and engine outputs
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			error_count_exceeded <= 1'b0;
			error_passive <= 1'b0;
			error_irq <= 1'b0;
			status_irq <= 1'b0;
			bus_enable <= 1'b0;
			low_power <= 1'b0;
			engine_rx <= 1'b1;
			can_transmit_pin <= 1'b1;
		end
		else
		begin
			error_count_exceeded <= error_threshold_select
				? (tx_error_counter > `CMC_THR_HIGH || rx_error_counter > `CMC_THR_HIGH)
				: (tx_error_counter > `CMC_THR_LOW || rx_error_counter > `CMC_THR_LOW);
			error_passive <= (tx_error_counter > `CMC_PASSIVE)
				|| (rx_error_counter > `CMC_PASSIVE);
			error_irq <= error_irq_enable && can_irq_enable && global_irq_enable
				&& (bus_off_flag || error_count_exceeded);
			status_irq <= stat_pend_q;
			bus_enable <= (bus_q == cmc_pkg::CMC_ON) && !lp_active_q;
			low_power <= lp_active_q;
			engine_rx <= rx_fb;
			can_transmit_pin <= baud_detect_mode || engine_tx;
		end
	end

	// Register read port; unmapped reads give zero
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			sfr_rdata <= 8'h00;
		else if (sfr_rd)
		begin
			if (sfr_addr == `CMC_ADDR_CTRL)
				sfr_rdata <= {error_irq_enable, status_irq_enable, power_down_request,
					siesta_q, module_reset && mrst_done_q, baud_detect_mode,
					error_threshold_select, software_init};
			else if (sfr_addr == `CMC_ADDR_STAT)
				sfr_rdata <= {bus_off_flag, error_count_exceeded, wake_status,
					rxs_q, txs_q, bus_error_field};
			else if (sfr_addr == `CMC_ADDR_TEC)
				sfr_rdata <= tx_error_counter[7:0];
			else if (sfr_addr == `CMC_ADDR_REC)
				sfr_rdata <= rx_error_counter[7:0];
			else
				sfr_rdata <= 8'h00;
		end
	end

	// Message memory write gate, one cycle late
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			mem_wr_ok <= 1'b0;
			mem_addr_q <= 8'h00;
			mem_wdata_q <= 8'h00;
		end
		else
		begin
			mem_wr_ok <= mem_wr && (software_init || mem_addr >= `CMC_PROT_BYTES);
			mem_addr_q <= mem_addr;
			mem_wdata_q <= mem_wdata;
		end
	end

	AST_ERR_IRQ: assert property (@(posedge clk) disable iff (!rst_n_s)
		error_irq |-> $past(error_irq_enable && can_irq_enable && global_irq_enable))
		else $error("error interrupt without enables");
	AST_WAKE: assert property (@(posedge clk) disable iff (!rst_n_s)
		sfr_rd && sfr_addr == `CMC_ADDR_STAT
		|=> sfr_rdata[5] == $past(power_down_request | siesta_q))
		else $error("wake status mismatch");
	AST_SIESTA_INIT: assert property (@(posedge clk) disable iff (!rst_n_s)
		wr_ctrl && sfr_wdata[`CMC_B_SWINIT] |=> !siesta_q)
		else $error("siesta survived init write");
	AST_MRST_CNT: assert property (@(posedge clk) disable iff (!rst_n_s)
		soft_rst |=> tx_error_counter == 9'h000 && rx_error_counter == 9'h000
		&& software_init)
		else $error("module reset left counters");
	AST_MRST_TIMED: assert property (@(posedge clk) disable iff (!rst_n_s)
		$rose(module_reset) |-> $past(wr_ctrl && timed_ok))
		else $error("module reset set without timed access");
	AST_PROT: assert property (@(posedge clk) disable iff (!rst_n_s)
		mem_wr_ok && mem_addr_q < `CMC_PROT_BYTES |-> $past(software_init))
		else $error("protected byte written without init");
	AST_TEC_LOCK: assert property (@(posedge clk) disable iff (!rst_n_s)
		wr_tec && !software_init && !tx_err_inc && !tx_ok && !bus_off_hit
		&& bus_q != cmc_pkg::CMC_RECOVER && !soft_rst
		|=> $stable(tx_error_counter))
		else $error("counter written without init");
	AST_BAUD_PIN: assert property (@(posedge clk) disable iff (!rst_n_s)
		baud_detect_mode ##1 baud_detect_mode |-> can_transmit_pin)
		else $error("pin driven in baud detect");
	AST_THR: assert property (@(posedge clk) disable iff (!rst_n_s)
		##1 error_count_exceeded == $past(error_threshold_select
		? (tx_error_counter > 9'h07f || rx_error_counter > 9'h07f)
		: (tx_error_counter > 9'h05f || rx_error_counter > 9'h05f)))
		else $error("count exceeded flag wrong");
	AST_BUS_OFF_FLAG_INIT: assert property (@(posedge clk) disable iff (!rst_n_s)
		bus_off_flag |-> !software_init)
		else $error("init set during bus-off");
	AST_ON_WAIT: assert property (@(posedge clk) disable iff (!rst_n_s)
		$changed(bus_q) && bus_q == cmc_pkg::CMC_ON |-> $past(run_done))
		else $error("joined bus without recessive run");
	AST_ZERO_TIMING: assert property (@(posedge clk) disable iff (!rst_n_s)
		timing_zero && !bus_off_hit && bus_q != cmc_pkg::CMC_RECOVER |=> software_init)
		else $error("init cleared with zero timing");
endmodule // cmc_ctrl
`default_nettype wire

// >>> verilog/cmc_params.svh
// Constants of the CAN mode and control block
`ifndef CMC_PARAMS_SVH
`define CMC_PARAMS_SVH
`define CMC_ADDR_CTRL 8'ha3
`define CMC_ADDR_STAT 8'ha4
`define CMC_ADDR_TEC 8'ha6
`define CMC_ADDR_REC 8'ha7
`define CMC_CTRL_RESET 8'h09
`define CMC_B_ERRIE 7
`define CMC_B_STATUS_IRQ_ENABLE 6
`define CMC_B_PDE 5
`define CMC_B_SIESTA 4
`define CMC_B_MRST 3
`define CMC_B_BAUD 2
`define CMC_B_THR 1
`define CMC_B_SWINIT 0
`define CMC_THR_LOW 9'h05f
`define CMC_THR_HIGH 9'h07f
`define CMC_PASSIVE 9'h080
`define CMC_BUS_OFF 9'h100
`define CMC_TX_ERR_STEP 9'h008
`define CMC_RUN_LEN 4'hb
`define CMC_RECOV_RUNS 8'h80
`define CMC_PROT_BYTES 8'h10
`define CMC_ER_NONE 3'h0
`define CMC_ER_NOCHG 3'h7
`endif

// >>> verilog/cmc_pkg.sv
// Types of the CAN mode and control block
package cmc_pkg;
	typedef enum logic [1:0] {
		CMC_OFFLINE = 2'b00,
		CMC_WAIT = 2'b01,
		CMC_ON = 2'b11,
		CMC_RECOVER = 2'b10
	} cmc_bus_t;
endpackage

// >>> verilog/cmc_run.sv
// Counter of consecutive recessive bits
`timescale 1ns/100ps
`default_nettype none
`include "cmc_params.svh"
module cmc_run (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic clear,
	input wire logic bit_tick,
	input wire logic bit_val,
	// One-cycle pulse after a full run
	output logic run_done
);
	logic [3:0] cnt_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= 4'h0;
			run_done <= 1'b0;
		end
		else
		begin
			run_done <= 1'b0;
			if (clear)
				cnt_q <= 4'h0;
			else if (bit_tick)
			begin
				// A dominant bit restarts the run
				if (!bit_val)
					cnt_q <= 4'h0;
				else if (cnt_q == `CMC_RUN_LEN - 4'h1)
				begin
					cnt_q <= 4'h0;
					run_done <= 1'b1;
				end
				else
					cnt_q <= cnt_q + 4'h1;
			end
		end
	end
endmodule // cmc_run
`default_nettype wire

// >>> verilog/cmc_sync.sv
// Two-stage synchroniser for the receive pin
`timescale 1ns/100ps
`default_nettype none
module cmc_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic d,
	output logic q
);
	logic s1_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q <= 1'b1;
			q <= 1'b1;
		end
		else
		begin
			s1_q <= d;
			q <= s1_q;
		end
	end
endmodule // cmc_sync
`default_nettype wire
